// [verilog/timer16_defines.vh]
/*
 * constants for the 16-bit timer/counter with input capture:
 * register offsets, field positions, reset values and clock select codes.
 * assumes an 8-bit cpu i/o port with a 4-bit register index.
 */
`ifndef TIMER16_DEFINES_VH
`define TIMER16_DEFINES_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFS_CTRL_A 4'h0
`define OFS_CTRL_B 4'h1
`define OFS_CNT_LO 4'h2
`define OFS_CNT_HI 4'h3
`define OFS_CAP_LO 4'h4
`define OFS_CAP_HI 4'h5
`define OFS_CMPA_LO 4'h6
`define OFS_CMPA_HI 4'h7
`define OFS_CMPB_LO 4'h8
`define OFS_CMPB_HI 4'h9
`define OFS_MASK 4'ha
`define OFS_FLAGS 4'hb
`define OFS_CMP_CTRL 4'hc

// ----------------------------------------
// field positions
// ----------------------------------------
`define B_NF_EN 7
`define B_EDGE_RISE 6
`define B_WGM_HI_MSB 4
`define B_WGM_HI_LSB 3
`define B_CS_MSB 2
`define B_WGM_LO_MSB 1
`define B_CAP 5
`define B_OVF 0
`define B_TRIG_SEL 2

// ----------------------------------------
// reset values and fixed levels
// ----------------------------------------
`define RST_BYTE 8'h00
`define RST_WORD 16'h0000
`define VAL_MAX 16'hffff
`define VAL_BOTTOM 16'h0000
`define TOP_8BIT 16'h00ff
`define TOP_9BIT 16'h01ff
`define TOP_10BIT 16'h03ff
`define FILTER_SAMPLES 4

// ----------------------------------------
// clock select codes
// ----------------------------------------
`define CS_STOP 3'h0
`define CS_SYS 3'h1
`define CS_DIV8 3'h2
`define CS_DIV64 3'h3
`define CS_DIV256 3'h4
`define CS_DIV1024 3'h5
`define CS_EXT_FALL 3'h6
`define CS_EXT_RISE 3'h7

`endif

// [verilog/capture_filter.v]
/*
 * noise filter in front of the capture edge detector.
 * assumes its input is synchronous to clk; no prescaler involved.
 */
`timescale 1ns/1ps
`include "timer16_defines.vh"

module capture_filter
#(
	parameter SAMPLES = `FILTER_SAMPLES
)
(
	input wire clk,
	input wire nrst,
	input wire enable,
	input wire din,
	output reg dout
);

// ----------------------------------------
// sample history
// ----------------------------------------
reg [SAMPLES-1:0] hist_r;
wire all_high;
wire all_low;

assign all_high = &hist_r;
assign all_low = ~|hist_r;

always @(posedge clk or negedge nrst)
begin
	if (!nrst)
	begin
		hist_r <= {SAMPLES{1'b0}};
		dout <= 1'b0;
	end
	else
	begin
		hist_r <= {hist_r[SAMPLES-2:0], din};
		if (!enable)
			dout <= din;
		else if (all_high)
			dout <= 1'b1;
		else if (all_low)
			dout <= 1'b0;
	end
end

endmodule

// [verilog/timer16_capture.v]
/*
 * 16-bit up/down timer/counter with input capture and a shared
 * high-byte holding register on an 8-bit cpu i/o port.
 * assumes tick inputs are one-cycle pulses from an outside prescaler
 * and edge detector, all synchronous to clk.
 */
`timescale 1ns/1ps
`include "timer16_defines.vh"

// Notes on behaviour
// - counter seen as low and high bytes; high location is the holding byte
// - reading counter low byte loads counter high byte into holding byte
// - writing counter low byte loads holding byte and data together
// - each timer tick clears, increments or decrements per mode
// - three-bit clock select picks tick source; zero stops counting
// - counter readable and writable with or without ticks
// - cpu counter write beats clear and count in same cycle
// - four-bit waveform mode split over control registers a and b
// - overflow flag set where mode says; may request interrupt
// - matching trigger edge copies whole counter into capture register
// - capture flag set with the copy; irq only when enabled
// - capture flag cleared by service or by writing one
// - capture low read first loads capture high into holding byte
// - capture register writable only in modes using it as top
// - trigger select picks pin or comparator; software clears flag after
// - filter output changes only after four agreeing samples
// - filter enable bit in control b; system clock; four cycles latency
// - filter and edge detector run in every mode; capture events masked in capture-top modes
// - software-driven capture pin captures like an outside event
// - each capture overwrites the capture register
// - holding byte kept between accesses, shareable by several writes
// - compare register reads bypass the holding byte
// - top is fixed, compare a or capture; bottom is zero
module timer16_capture
(
	input wire clk,
	input wire nrst,
	input wire [3:0] io_addr,
	input wire io_wr,
	input wire io_rd,
	input wire [7:0] io_wdata,
	output reg [7:0] io_rdata,
	input wire tick_div8,
	input wire tick_div64,
	input wire tick_div256,
	input wire tick_div1024,
	input wire ext_rise,
	input wire ext_fall,
	input wire capture_pin,
	input wire comparator_output,
	input wire capture_irq_ack,
	input wire overflow_irq_ack,
	output wire capture_irq,
	output wire overflow_irq,
	output reg [15:0] count_value,
	output wire [3:0] waveform_mode_field,
	output wire top_hit,
	output wire bottom_hit,
	output wire count_down
);

// ----------------------------------------
// registers
// ----------------------------------------
reg [7:0] control_reg_a_r;
reg [7:0] control_reg_b_r;
reg [7:0] mask_r;
reg [7:0] comparator_control_reg_r;
reg [7:0] temp_r;
reg [15:0] capture_register_r;
reg [15:0] cmpa_r;
reg [15:0] cmpb_r;
reg capture_flag_r;
reg overflow_flag_r;
reg dir_down_r;
reg edge_prev_r;
reg [15:0] count_nxt;
reg dir_down_nxt;
reg ovf_event;

wire [2:0] clock_select_field;
wire noise_filter_enable;
wire edge_rise_sel;
wire capture_irq_enable;
wire comparator_trigger_select;
wire timer_clock;
wire [15:0] top_val;
wire icr_top_mode;
wire dual_mode;
wire ctc_mode;
wire trig_raw;
wire filt_out;
wire cap_event;
wire wr_cnt_lo;
wire wr_cap_lo;

// ----------------------------------------
// mode decode functions
// ----------------------------------------
function uses_icr_top;
	input [3:0] m;
	begin
		uses_icr_top = (m == 4'h8) || (m == 4'ha) || (m == 4'hc) || (m == 4'he);
	end
endfunction

function is_dual_slope;
	input [3:0] m;
	begin
		is_dual_slope = (m == 4'h1) || (m == 4'h2) || (m == 4'h3) || (m[3] && !m[2]);
	end
endfunction

function [15:0] top_of;
	input [3:0] m;
	input [15:0] a;
	input [15:0] icr;
	begin
		case (m)
			4'h1, 4'h5: top_of = `TOP_8BIT;
			4'h2, 4'h6: top_of = `TOP_9BIT;
			4'h3, 4'h7: top_of = `TOP_10BIT;
			4'h4, 4'h9, 4'hb, 4'hf: top_of = a;
			4'h8, 4'ha, 4'hc, 4'he: top_of = icr;
			default: top_of = `VAL_MAX;
		endcase
	end
endfunction

// ----------------------------------------
// control fields
// ----------------------------------------
assign waveform_mode_field = {control_reg_b_r[`B_WGM_HI_MSB:`B_WGM_HI_LSB],
	control_reg_a_r[`B_WGM_LO_MSB:0]};
assign clock_select_field = control_reg_b_r[`B_CS_MSB:0];
assign noise_filter_enable = control_reg_b_r[`B_NF_EN];
assign edge_rise_sel = control_reg_b_r[`B_EDGE_RISE];
assign capture_irq_enable = mask_r[`B_CAP];
assign comparator_trigger_select = comparator_control_reg_r[`B_TRIG_SEL];

assign icr_top_mode = uses_icr_top(waveform_mode_field);
assign dual_mode = is_dual_slope(waveform_mode_field);
assign ctc_mode = (waveform_mode_field == 4'h4) || (waveform_mode_field == 4'hc);
assign top_val = top_of(waveform_mode_field, cmpa_r, capture_register_r);

// ----------------------------------------
// timer clock select
// ----------------------------------------
reg tick_sel;
always @*
begin
	case (clock_select_field)
		`CS_STOP: tick_sel = 1'b0;
		`CS_SYS: tick_sel = 1'b1;
		`CS_DIV8: tick_sel = tick_div8;
		`CS_DIV64: tick_sel = tick_div64;
		`CS_DIV256: tick_sel = tick_div256;
		`CS_DIV1024: tick_sel = tick_div1024;
		`CS_EXT_FALL: tick_sel = ext_fall;
		`CS_EXT_RISE: tick_sel = ext_rise;
		default: tick_sel = 1'b0;
	endcase
end
assign timer_clock = tick_sel;

assign top_hit = (count_value == top_val);
assign bottom_hit = (count_value == `VAL_BOTTOM);
assign count_down = dir_down_r;

// ----------------------------------------
// counter sequence
// ----------------------------------------
always @*
begin
	count_nxt = count_value;
	dir_down_nxt = dir_down_r;
	ovf_event = 1'b0;
	if (timer_clock)
	begin
		if (dual_mode)
		begin
			if (!dir_down_r && top_hit)
			begin
				dir_down_nxt = 1'b1;
				count_nxt = count_value - 16'h0001;
			end
			else if (dir_down_r && bottom_hit)
			begin
				dir_down_nxt = 1'b0;
				count_nxt = count_value + 16'h0001;
				ovf_event = 1'b1;
			end
			else if (dir_down_r)
				count_nxt = count_value - 16'h0001;
			else
				count_nxt = count_value + 16'h0001;
		end
		else
		begin
			dir_down_nxt = 1'b0;
			if (top_hit)
				count_nxt = `VAL_BOTTOM;
			else
				count_nxt = count_value + 16'h0001;
			if (ctc_mode)
				ovf_event = (count_value == `VAL_MAX);
			else
				ovf_event = top_hit;
		end
	end
end

// ----------------------------------------
// capture trigger path
// ----------------------------------------
assign trig_raw = comparator_trigger_select ? comparator_output : capture_pin;

capture_filter #(
	.SAMPLES(`FILTER_SAMPLES)
) capture_filter_i (
	.clk(clk),
	.nrst(nrst),
	.enable(noise_filter_enable),
	.din(trig_raw),
	.dout(filt_out)
);

always @(posedge clk or negedge nrst)
begin
	if (!nrst)
		edge_prev_r <= 1'b0;
	else
		edge_prev_r <= filt_out;
end

assign cap_event = !icr_top_mode && (edge_rise_sel ? (filt_out && !edge_prev_r)
	: (!filt_out && edge_prev_r));

// ----------------------------------------
// cpu access decode
// ----------------------------------------
assign wr_cnt_lo = io_wr && (io_addr == `OFS_CNT_LO);
assign wr_cap_lo = io_wr && (io_addr == `OFS_CAP_LO) && icr_top_mode;

// ----------------------------------------
// counter, holding byte and data registers
// ----------------------------------------
always @(posedge clk or negedge nrst)
begin
	if (!nrst)
	begin
		count_value <= `RST_WORD;
		dir_down_r <= 1'b0;
		temp_r <= `RST_BYTE;
		capture_register_r <= `RST_WORD;
		cmpa_r <= `RST_WORD;
		cmpb_r <= `RST_WORD;
		control_reg_a_r <= `RST_BYTE;
		control_reg_b_r <= `RST_BYTE;
		mask_r <= `RST_BYTE;
		comparator_control_reg_r <= `RST_BYTE;
	end
	else
	begin
		dir_down_r <= dir_down_nxt;
		if (wr_cnt_lo)
			count_value <= {temp_r, io_wdata};
		else
			count_value <= count_nxt;
		if (cap_event)
			capture_register_r <= count_value;
		else if (wr_cap_lo)
			capture_register_r <= {temp_r, io_wdata};
		if (io_rd && io_addr == `OFS_CNT_LO)
			temp_r <= count_value[15:8];
		else if (io_rd && io_addr == `OFS_CAP_LO)
			temp_r <= capture_register_r[15:8];
		else if (io_wr && (io_addr == `OFS_CNT_HI || io_addr == `OFS_CAP_HI
			|| io_addr == `OFS_CMPA_HI || io_addr == `OFS_CMPB_HI))
			temp_r <= io_wdata;
		if (io_wr)
		begin
			case (io_addr)
				`OFS_CTRL_A: control_reg_a_r <= io_wdata;
				`OFS_CTRL_B: control_reg_b_r <= io_wdata;
				`OFS_CMPA_LO: cmpa_r <= {temp_r, io_wdata};
				`OFS_CMPB_LO: cmpb_r <= {temp_r, io_wdata};
				`OFS_MASK: mask_r <= io_wdata;
				`OFS_CMP_CTRL: comparator_control_reg_r <= io_wdata;
				default: mask_r <= mask_r;
			endcase
		end
	end
end

// ----------------------------------------
// flags
// ----------------------------------------
wire flag_wr;
assign flag_wr = io_wr && (io_addr == `OFS_FLAGS);

always @(posedge clk or negedge nrst)
begin
	if (!nrst)
	begin
		capture_flag_r <= 1'b0;
		overflow_flag_r <= 1'b0;
	end
	else
	begin
		if (cap_event)
			capture_flag_r <= 1'b1;
		else if (capture_irq_ack || (flag_wr && io_wdata[`B_CAP]))
			capture_flag_r <= 1'b0;
		if (ovf_event)
			overflow_flag_r <= 1'b1;
		else if (overflow_irq_ack || (flag_wr && io_wdata[`B_OVF]))
			overflow_flag_r <= 1'b0;
	end
end

assign capture_irq = capture_flag_r && capture_irq_enable;
assign overflow_irq = overflow_flag_r && mask_r[`B_OVF];

// ----------------------------------------
// read data
// ----------------------------------------
reg [7:0] rd_mux;
always @*
begin
	case (io_addr)
		`OFS_CTRL_A: rd_mux = control_reg_a_r;
		`OFS_CTRL_B: rd_mux = control_reg_b_r;
		`OFS_CNT_LO: rd_mux = count_value[7:0];
		`OFS_CNT_HI: rd_mux = temp_r;
		`OFS_CAP_LO: rd_mux = capture_register_r[7:0];
		`OFS_CAP_HI: rd_mux = temp_r;
		`OFS_CMPA_LO: rd_mux = cmpa_r[7:0];
		`OFS_CMPA_HI: rd_mux = cmpa_r[15:8];
		`OFS_CMPB_LO: rd_mux = cmpb_r[7:0];
		`OFS_CMPB_HI: rd_mux = cmpb_r[15:8];
		`OFS_MASK: rd_mux = mask_r;
		`OFS_FLAGS: rd_mux = {2'b00, capture_flag_r, 4'h0, overflow_flag_r};
		`OFS_CMP_CTRL: rd_mux = comparator_control_reg_r;
		default: rd_mux = `RST_BYTE;
	endcase
end

always @(posedge clk or negedge nrst)
begin
	if (!nrst)
		io_rdata <= `RST_BYTE;
	else if (io_rd)
		io_rdata <= rd_mux;
end

endmodule

// [tb/prescale_model.sv]
/* prescaler model: one-cycle ticks every 8, 64, 256 and 1024 clocks.
   assumes the timer's clk and nrst. */
`timescale 1ns/1ps
module prescale_model
(
	input wire clk,
	input wire nrst,
	output wire [3:0] ticks
);
	reg [9:0] n_r;
	always @(posedge clk or negedge nrst)
		if (!nrst)
			n_r <= 10'h000;
		else
			n_r <= n_r + 10'h001;
	assign ticks = {n_r == 10'h3ff, n_r[7:0] == 8'hff, n_r[5:0] == 6'h3f, n_r[2:0] == 3'h7};
endmodule

// [tb/timer16_capture_asserts.sv]
/* checker for the timer with capture.
   sees only top ports; tracks control writes itself. */
`timescale 1ns/1ps
module timer16_checker
(
	input wire clk,
	input wire nrst,
	input wire [3:0] io_addr,
	input wire io_wr,
	input wire io_rd,
	input wire [7:0] io_wdata,
	input wire [7:0] io_rdata,
	input wire capture_irq,
	input wire overflow_irq,
	input wire [15:0] count_value,
	input wire [3:0] waveform_mode_field,
	input wire top_hit,
	input wire bottom_hit,
	input wire count_down
);
	reg [7:0] a_r;
	reg [7:0] b_r;
	reg [7:0] m_r;
	wire [7:0] c_lo = count_value[7:0];
	wire [7:0] c_hi = count_value[15:8];
	wire lo_wr = io_wr && io_addr == 4'h2;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	// ---------
	// control copies
	// ---------
	always @(posedge clk or negedge nrst)
		if (!nrst)
		begin
			a_r <= 8'h00;
			b_r <= 8'h00;
			m_r <= 8'h00;
		end
		else if (io_wr)
		begin
			if (io_addr == 4'h0)
				a_r <= io_wdata;
			if (io_addr == 4'h1)
				b_r <= io_wdata;
			if (io_addr == 4'ha)
				m_r <= io_wdata;
		end
	sequence s_lo_rd;
		io_rd && io_addr == 4'h2;
	endsequence
	sequence s_hi_rd;
		io_rd && io_addr == 4'h3;
	endsequence
	a_low_read: assert property (s_lo_rd |=> io_rdata == $past(c_lo))
		else $error("counter low read wrong");
	a_pair_read: assert property (s_lo_rd ##1 s_hi_rd |=> io_rdata == $past(c_hi, 2))
		else $error("counter high read wrong");
	a_low_write: assert property (lo_wr |=> c_lo == $past(io_wdata))
		else $error("counter write lost");
	a_stop_holds: assert property (b_r[2:0] == 3'h0 && !lo_wr |=> $stable(count_value))
		else $error("stopped counter moved");
	a_count_up: assert property (b_r[2:0] == 3'h1 && waveform_mode_field == 4'h0 && !lo_wr
		|=> count_value == $past(count_value) + 16'h0001)
		else $error("counter did not step");
	a_dual_turn: assert property (b_r[2:0] == 3'h1 && waveform_mode_field == 4'h1 && top_hit && !count_down
		&& !lo_wr |=> count_down && count_value == $past(count_value) - 16'h0001)
		else $error("dual slope did not turn");
	a_mode_split: assert property (waveform_mode_field == {b_r[4:3], a_r[1:0]})
		else $error("mode field wrong");
	a_cap_gate: assert property (!m_r[5] |-> !capture_irq)
		else $error("capture irq unmasked");
	a_ovf_gate: assert property (!m_r[0] |-> !overflow_irq)
		else $error("overflow irq unmasked");
	a_top_normal: assert property (waveform_mode_field == 4'h0 |-> top_hit == (count_value == 16'hffff))
		else $error("top wrong");
	a_bottom_zero: assert property (bottom_hit == (count_value == 16'h0000))
		else $error("bottom wrong");
endmodule
bind timer16_capture timer16_checker timer16_checker_i(.clk(clk), .nrst(nrst), .io_addr(io_addr),
	.io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .capture_irq(capture_irq),
	.overflow_irq(overflow_irq), .count_value(count_value), .waveform_mode_field(waveform_mode_field),
	.top_hit(top_hit), .bottom_hit(bottom_hit), .count_down(count_down));

// [tb/timer16_capture_bench.sv]
/* bench: register tests of the timer with capture.
   assumes design, checker and prescale model compiled first. */
`timescale 1ns/1ps
module timer16_capture_bench;
	reg clk = 0;
	reg nrst = 0;
	reg io_wr = 0;
	reg io_rd = 0;
	reg pin = 0;
	reg cmp = 0;
	reg ack = 0;
	reg er = 0;
	reg ef = 0;
	reg oack = 0;
	wire cd;
	reg [3:0] io_addr = 4'h0;
	reg [7:0] io_wdata = 8'h00;
	wire [7:0] io_rdata;
	wire [3:0] tk;
	wire ci;
	wire oi;
	wire bh;
	integer failures = 0;
	integer num_checks = 0;
	timer16_capture timer16_capture_i(.clk(clk), .nrst(nrst), .io_addr(io_addr), .io_wr(io_wr),
		.io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .tick_div8(tk[0]), .tick_div64(tk[1]),
		.tick_div256(tk[2]), .tick_div1024(tk[3]), .ext_rise(er), .ext_fall(ef), .capture_pin(pin),
		.comparator_output(cmp), .capture_irq_ack(ack), .overflow_irq_ack(oack), .capture_irq(ci),
		.overflow_irq(oi), .count_value(), .waveform_mode_field(), .top_hit(), .bottom_hit(bh),
		.count_down(cd));
	prescale_model prescale_model_i(.clk(clk), .nrst(nrst), .ticks(tk));
	// ---------
	// access tasks
	// ---------
	task chk(input [15:0] s, input [15:0] e, input [63:0] nm);
	begin
		num_checks = num_checks + 1;
		if (s !== e)
		begin
			failures = failures + 1;
			$display("wrong value %0s expected %h seen %h", nm, e, s);
		end
	end
	endtask
	task tick(input integer n);
		repeat (n) @(negedge clk);
	endtask
	task ext_pulses;
	begin
		er = 1;
		tick(1);
		er = 0;
		ef = 1;
		tick(1);
		ef = 0;
		er = 1;
		tick(1);
		er = 0;
		ef = 1;
		tick(1);
		ef = 0;
		er = 1;
		tick(1);
		er = 0;
	end
	endtask
	task wr8(input [3:0] a, input [7:0] d);
	begin
		@(negedge clk);
		io_addr = a;
		io_wdata = d;
		io_wr = 1;
		@(negedge clk);
		io_wr = 0;
	end
	endtask
	task wr16(input [3:0] a, input [15:0] d);
	begin
		wr8(a + 4'h1, d[15:8]);
		wr8(a, d[7:0]);
	end
	endtask
	task rd8(input [3:0] a, input [7:0] e, input [63:0] nm);
	begin
		@(negedge clk);
		io_addr = a;
		io_rd = 1;
		@(negedge clk);
		io_rd = 0;
		chk({8'h00, io_rdata}, {8'h00, e}, nm);
	end
	endtask
	task rd16(input [3:0] a, input [15:0] e, input [63:0] nm);
	begin
		@(negedge clk);
		io_addr = a;
		io_rd = 1;
		@(negedge clk);
		io_addr = a + 4'h1;
		chk({8'h00, io_rdata}, {8'h00, e[7:0]}, nm);
		@(negedge clk);
		io_rd = 0;
		chk({8'h00, io_rdata}, {8'h00, e[15:8]}, nm);
	end
	endtask
	task finish_test;
	begin
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	end
	endtask
	// ---------
	// tests
	// ---------
	initial
	begin
		forever #20 clk = ~clk;
	end
	initial
	begin
		repeat (50000) @(posedge clk);
		failures = failures + 1;
		finish_test;
	end
	initial
	begin
		tick(12);
		nrst = 1;
		rd8(4'h1, 8'h00, "ctrl_b");
		rd8(4'hd, 8'h00, "unmapped");
		chk(bh, 1, "bottom");
		$display("test reset done");
		wr16(4'h2, 16'h01ff);
		rd16(4'h2, 16'h01ff, "count");
		wr16(4'h6, 16'h1256);
		wr8(4'h3, 8'hab);
		wr8(4'h2, 8'hcd);
		rd16(4'h2, 16'habcd, "count");
		rd16(4'h6, 16'h1256, "cmp_a");
		wr8(4'h8, 8'h77);
		rd16(4'h8, 16'hab77, "cmp_b");
		$display("test access done");
		wr16(4'h2, 16'hfffe);
		wr8(4'ha, 8'h01);
		wr8(4'h1, 8'h01);
		wr8(4'h1, 8'h00);
		chk(oi, 1, "ovf_irq");
		wr8(4'hb, 8'h01);
		rd8(4'hb, 8'h00, "flags");
		$display("test overflow done");
		wr16(4'h2, 16'h4321);
		wr8(4'ha, 8'h20);
		wr8(4'h1, 8'h40);
		pin = 1;
		tick(3);
		chk(ci, 1, "cap_irq");
		rd16(4'h4, 16'h4321, "capture");
		ack = 1;
		tick(1);
		ack = 0;
		tick(1);
		chk(ci, 0, "cap_irq");
		pin = 0;
		tick(3);
		rd8(4'hb, 8'h00, "flags");
		wr16(4'h2, 16'h5555);
		pin = 1;
		tick(3);
		rd16(4'h4, 16'h5555, "capture");
		wr8(4'hb, 8'h20);
		rd8(4'hb, 8'h00, "flags");
		wr8(4'ha, 8'h00);
		wr8(4'h1, 8'h00);
		pin = 0;
		tick(3);
		chk(ci, 0, "cap_irq");
		rd8(4'hb, 8'h20, "flags");
		$display("test capture done");
		wr8(4'hc, 8'h04);
		wr8(4'hb, 8'h20);
		wr8(4'h1, 8'h40);
		cmp = 1;
		tick(3);
		rd8(4'hb, 8'h20, "flags");
		wr8(4'hb, 8'h20);
		pin = 1;
		tick(3);
		rd8(4'hb, 8'h00, "flags");
		wr8(4'hc, 8'h00);
		pin = 0;
		$display("test trigger done");
		wr8(4'h1, 8'hc0);
		wr8(4'hb, 8'h20);
		pin = 1;
		tick(3);
		pin = 0;
		tick(8);
		rd8(4'hb, 8'h00, "flags");
		pin = 1;
		tick(4);
		rd8(4'hb, 8'h00, "flags");
		tick(3);
		rd8(4'hb, 8'h20, "flags");
		$display("test filter done");
		wr8(4'h1, 8'h18);
		wr8(4'hb, 8'h20);
		pin = 0;
		tick(3);
		pin = 1;
		tick(8);
		rd8(4'hb, 8'h00, "flags");
		wr16(4'h4, 16'h9abc);
		rd16(4'h4, 16'h9abc, "capture");
		wr8(4'h1, 8'h00);
		wr16(4'h4, 16'h0000);
		rd16(4'h4, 16'h9abc, "capture");
		$display("test top mode done");
		wr16(4'h2, 16'h0100);
		wr8(4'h1, 8'h02);
		tick(62);
		wr8(4'h1, 8'h00);
		rd16(4'h2, 16'h0108, "count");
		wr8(4'h1, 8'h07);
		ext_pulses;
		wr8(4'h1, 8'h00);
		rd16(4'h2, 16'h010b, "count");
		wr8(4'h1, 8'h06);
		ext_pulses;
		wr8(4'h1, 8'h00);
		rd16(4'h2, 16'h010d, "count");
		$display("test clock done");
		wr16(4'h2, 16'h00fd);
		wr8(4'h0, 8'h01);
		wr8(4'h1, 8'h01);
		tick(2);
		wr8(4'h1, 8'h00);
		chk(cd, 1, "count_dn");
		rd16(4'h2, 16'h00fd, "count");
		wr16(4'h2, 16'h0001);
		wr8(4'ha, 8'h01);
		wr8(4'h1, 8'h01);
		tick(1);
		wr8(4'h1, 8'h00);
		chk(oi, 1, "ovf_irq");
		chk(cd, 0, "count_dn");
		rd16(4'h2, 16'h0002, "count");
		oack = 1;
		tick(1);
		oack = 0;
		tick(1);
		chk(oi, 0, "ovf_irq");
		$display("test dual done");
		finish_test;
	end
endmodule
